// >>> dv/far_side_model.sv
// behavioural host port time-out counter, timer 2 event and timer 0 pin
// assumes the bench steers it from pclk rising edges
`timescale 1ns/1ps
module far_side_model (
  input  wire logic       pclk,            // clock
  input  wire logic       presetn,         // async reset, active low
  input  wire logic       count_en,        // host port burst write pending
  input  wire logic       pin_run,         // pin toggles every cycle
  input  wire logic       wd_fire,         // timer 2 expiry request
  output logic            timeout_active,  // counter runs
  output logic [7:0]      timeout_count,   // counter value
  output logic            watchdog_event,  // to the bank
  output logic            timer0_input_pin // pin level
);
  logic [7:0] next_count;
  logic       next_pin;

  // counter clears while no burst write is pending
  always_comb begin
    next_count = count_en ? timeout_count + 8'h01 : 8'h00;
    next_pin   = pin_run ? ~timer0_input_pin : timer0_input_pin;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_count    <= 8'h00;
      timer0_input_pin <= 1'b0;
    end else begin
      timeout_count    <= next_count;
      timer0_input_pin <= next_pin;
    end
  end

  assign timeout_active = count_en;
  assign watchdog_event = wd_fire;
endmodule // far_side_model

// >>> dv/peripheral_system_control_regs_tb.sv
// self-checking bench of the peripheral system control register bank
// assumes the design files under rtl/ and dv/far_side_model.sv
`timescale 1ns/1ps
`include "sysctl_defs.svh"
module peripheral_system_control_regs_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic count_en, pin_run, wd_fire, active, wd_ev, pin;
  logic flush, t0_clk, mrr, err, e, prev;
  logic [7:0] tcount, tval;
  logic [8:0] d0, d1, d2;
  sysctl_pkg::dma_burst_size_cfg_t dma_cfg;
  int fails, tests_run, cycles, n;

  peripheral_system_control_regs u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .timeout_active(active),
    .timeout_count(tcount), .write_fifo_flush(flush),
    .burst_write_timeout_value(tval), .timer0_input_pin(pin),
    .timer0_clock_input(t0_clk), .watchdog_event(wd_ev),
    .max_reset_req(mrr), .dma_cfg(dma_cfg), .xfer_ctrl0_fifo_depth(d0),
    .xfer_ctrl1_fifo_depth(d1), .xfer_ctrl2_fifo_depth(d2));

  far_side_model u_far (
    .pclk(pclk), .presetn(presetn), .count_en(count_en),
    .pin_run(pin_run), .wd_fire(wd_fire), .timeout_active(active),
    .timeout_count(tcount), .watchdog_event(wd_ev),
    .timer0_input_pin(pin));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [31:0] a, wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [31:0] a, exp, input string msg);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp, msg);
    check({31'h0000_0000, err}, 32'h0000_0000, "error flag");
  endtask

  task automatic defaults();
    rd_chk(`ADDR_HOST_PORT_CTRL, 32'h0000_0000, "hp reset");
    rd_chk(`ADDR_TIMER_AUX_CTRL, 32'h0000_0001, "tmr reset");
    rd_chk(`ADDR_DMA_BURST_CFG, 32'h0000_0024, "dma reset");
    check({26'h0, dma_cfg}, 32'h0000_0024, "dma out reset");
    check({23'h0, d0}, 32'h0000_0080, "tc0 depth");
    check({23'h0, d1}, 32'h0000_0100, "tc1 depth");
    check({23'h0, d2}, 32'h0000_0080, "tc2 depth");
  endtask

  // upper bits ignore writes, burst codes all reach the outputs
  task automatic reserved_and_codes();
    apb(1'b1, `ADDR_HOST_PORT_CTRL, 32'hffff_fc3c);
    rd_chk(`ADDR_HOST_PORT_CTRL, 32'h0000_003c, "hp upper");
    check({24'h0, tval}, 32'h0000_003c, "tval out");
    apb(1'b1, `ADDR_TIMER_AUX_CTRL, 32'hffff_fffc);
    rd_chk(`ADDR_TIMER_AUX_CTRL, 32'h0000_0000, "tmr upper");
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, `ADDR_DMA_BURST_CFG, 32'hffff_ffc0 | (c * 32'h15));
      rd_chk(`ADDR_DMA_BURST_CFG, c * 32'h15, "dma code");
      check({26'h0, dma_cfg}, c * 32'h15, "dma out");
    end
    // unmapped write is ignored, unmapped read answers zero
    apb(1'b1, `ADDR_DMA_BURST_CFG + 32'h0000_0004, 32'h0000_0011);
    check({31'h0, err}, 32'h0000_0001, "unmapped wr err");
    check({26'h0, dma_cfg}, 32'h0000_003f, "unmapped ignored");
    apb(1'b0, `ADDR_DMA_BURST_CFG + 32'h0000_0004, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001, "unmapped err");
    check(rd, 32'h0000_0000, "unmapped data");
  endtask

  task automatic flush_test();
    apb(1'b1, `ADDR_HOST_PORT_CTRL, 32'h0000_0005);
    @(negedge pclk);
    e = 1'b0;
    @(posedge pclk);
    count_en <= 1'b1;
    repeat (12) begin
      @(negedge pclk);
      check({31'h0, flush}, {31'h0, e}, "flush");
      e = active && tcount == 8'h05;
    end
    @(posedge pclk);
    count_en <= 1'b0;
  endtask

  task automatic wd_test(input logic en);
    apb(1'b1, `ADDR_TIMER_AUX_CTRL, {31'h0, en});
    @(posedge pclk);
    wd_fire <= 1'b1;
    @(posedge pclk);
    wd_fire <= 1'b0;
    @(negedge pclk);
    check({31'h0, mrr}, {31'h0, en}, "max reset");
    @(negedge pclk);
    check({31'h0, mrr}, 32'h0000_0000, "max reset end");
  endtask

  task automatic prescale_test(input logic sel, input int exp);
    apb(1'b1, `ADDR_TIMER_AUX_CTRL, {30'h0, sel, 1'b1});
    repeat (16) @(negedge pclk);
    prev = t0_clk;
    n = 0;
    repeat (48) begin
      @(negedge pclk);
      if (t0_clk !== prev) n++;
      prev = t0_clk;
    end
    check(n, exp, "timer0 toggles");
  endtask

  task automatic reset_test();
    apb(1'b1, `ADDR_HOST_PORT_CTRL, 32'h0000_00a5);
    apb(1'b1, `ADDR_DMA_BURST_CFG, 32'h0000_0015);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    defaults();
  endtask

  initial begin
    {presetn, psel, penable, pwrite, count_en, pin_run, wd_fire} = '0;
    paddr = '0;
    pwdata = '0;
    fails = 0;
    tests_run = 0;
    cycles = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    defaults();
    reserved_and_codes();
    flush_test();
    wd_test(1'b1);
    wd_test(1'b0);
    @(posedge pclk);
    pin_run <= 1'b1;
    prescale_test(1'b0, 48);
    prescale_test(1'b1, 8);
    @(posedge pclk);
    pin_run <= 1'b0;
    reset_test();
    test_done();
  end
endmodule // peripheral_system_control_regs_tb

// >>> rtl/peripheral_system_control_regs.sv
// register bank tuning host port time-out, timer 0/2 and dma burst sizes
// assumes an apb master on pclk; consumers of the outputs sit outside
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`include "sysctl_defs.svh"
module peripheral_system_control_regs (
  input  wire logic                    pclk,            // clock, 40 MHz
  input  wire logic                    presetn,         // async reset
  input  wire logic                    psel,            // apb select
  input  wire logic                    penable,         // apb enable
  input  wire logic                    pwrite,          // apb direction
  input  wire logic [31:0]             paddr,           // apb byte address
  input  wire logic [31:0]             pwdata,          // apb write data
  output logic      [31:0]             prdata,          // apb read data
  output logic                         pready,          // apb ready
  output logic                         pslverr,         // unmapped address
  input  wire logic                    timeout_active,  // hp counter runs
  input  wire logic [`TIMEOUT_W-1:0]   timeout_count,   // hp counter value
  output logic                         write_fifo_flush, // hp fifo flush
  output logic [`TIMEOUT_W-1:0]        burst_write_timeout_value, // field
  input  wire logic                    timer0_input_pin, // timer 0 pin
  output logic                         timer0_clock_input, // to timer 0
  input  wire logic                    watchdog_event,  // from timer 2
  output logic                         max_reset_req,   // device reset req
  output sysctl_pkg::dma_burst_size_cfg_t dma_cfg,      // burst sizes
  output logic [`FIFO_DEPTH_W-1:0]     xfer_ctrl0_fifo_depth, // bytes
  output logic [`FIFO_DEPTH_W-1:0]     xfer_ctrl1_fifo_depth, // bytes
  output logic [`FIFO_DEPTH_W-1:0]     xfer_ctrl2_fifo_depth  // bytes
);

  // register state
  sysctl_pkg::host_port_timeout_ctrl_t hp_ctrl;
  sysctl_pkg::timer_aux_ctrl_t         tmr_ctrl;
  sysctl_pkg::dma_burst_size_cfg_t     dma_ctrl;
  sysctl_pkg::host_port_timeout_ctrl_t next_hp_ctrl;
  sysctl_pkg::timer_aux_ctrl_t         next_tmr_ctrl;
  sysctl_pkg::dma_burst_size_cfg_t     next_dma_ctrl;
  logic [31:0]                         next_prdata;
  logic                                next_write_fifo_flush;

  // bus decode
  logic setup_phase;
  logic access_phase;
  logic hit_hp;
  logic hit_tmr;
  logic hit_dma;
  logic hit_any;
  logic wr_hp;
  logic wr_tmr;
  logic wr_dma;

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_hp       = (paddr == `ADDR_HOST_PORT_CTRL);
  assign hit_tmr      = (paddr == `ADDR_TIMER_AUX_CTRL);
  assign hit_dma      = (paddr == `ADDR_DMA_BURST_CFG);
  assign hit_any      = hit_hp | hit_tmr | hit_dma;
  assign wr_hp        = access_phase & pwrite & hit_hp;
  assign wr_tmr       = access_phase & pwrite & hit_tmr;
  assign wr_dma       = access_phase & pwrite & hit_dma;

  // read data is fetched in the setup cycle, so every access is zero wait
  assign pready  = 1'b1;
  assign pslverr = access_phase & ~hit_any;

  // register update and read data capture
  always_comb begin
    next_hp_ctrl  = hp_ctrl;
    next_tmr_ctrl = tmr_ctrl;
    next_dma_ctrl = dma_ctrl;
    next_prdata   = prdata;
    if (wr_hp) begin
      next_hp_ctrl = pwdata[`HP_CTRL_W-1:0];
    end
    if (wr_tmr) begin
      next_tmr_ctrl = pwdata[`TIMER_CTRL_W-1:0];
    end
    if (wr_dma) begin
      next_dma_ctrl = pwdata[`DMA_CFG_W-1:0];
    end
    if (setup_phase && !pwrite) begin
      // bits above each field width read as zero
      next_prdata = 32'h0000_0000;
      if (hit_hp) begin
        next_prdata[`HP_CTRL_W-1:0] = hp_ctrl;
      end else if (hit_tmr) begin
        next_prdata[`TIMER_CTRL_W-1:0] = tmr_ctrl;
      end else if (hit_dma) begin
        next_prdata[`DMA_CFG_W-1:0] = dma_ctrl;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hp_ctrl  <= `HP_CTRL_RESET;
      tmr_ctrl <= {`PRESCALE_SEL_RESET, `WATCHDOG_RESET_ENABLE_RESET};
      dma_ctrl <= {`TC2_BURST_RESET, `TC1_BURST_RESET, `TC0_BURST_RESET};
      prdata   <= 32'h0000_0000;
    end else begin
      hp_ctrl  <= next_hp_ctrl;
      tmr_ctrl <= next_tmr_ctrl;
      dma_ctrl <= next_dma_ctrl;
      prdata   <= next_prdata;
    end
  end

  // host port write fifo flush on time-out match
  always_comb begin
    next_write_fifo_flush = timeout_active &&
      (timeout_count == hp_ctrl.burst_write_timeout_value);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      write_fifo_flush <= 1'b0;
    end else begin
      write_fifo_flush <= next_write_fifo_flush;
    end
  end

  // continuous field outputs
  assign burst_write_timeout_value = hp_ctrl.burst_write_timeout_value;
  assign dma_cfg                   = dma_ctrl;

  // depths do not follow the programmed burst size
  assign xfer_ctrl0_fifo_depth = `TC0_FIFO_DEPTH;
  assign xfer_ctrl1_fifo_depth = `TC1_FIFO_DEPTH;
  assign xfer_ctrl2_fifo_depth = `TC2_FIFO_DEPTH;

  timer0_prescaler #(
    .DIVIDE        (`PRESCALE_DIVIDE)
  ) u_prescaler (
    .pclk          (pclk),
    .presetn       (presetn),
    .prescale_sel  (tmr_ctrl.timer0_input_prescale_sel),
    .pin           (timer0_input_pin),
    .clock_out     (timer0_clock_input)
  );

  watchdog_reset_gate u_wdog_gate (
    .pclk           (pclk),
    .presetn        (presetn),
    .reset_enable   (tmr_ctrl.watchdog_reset_enable),
    .watchdog_event (watchdog_event),
    .max_reset_req  (max_reset_req)
  );

  // checks
  logic first_cycle;
  logic next_first_cycle;

  always_comb begin
    next_first_cycle = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_cycle <= 1'b1;
    end else begin
      first_cycle <= next_first_cycle;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_setup(logic hit);
    setup_phase && !pwrite && hit;
  endsequence

  sequence s_write_dma;
    access_phase && pwrite && hit_dma;
  endsequence

  a_flush_on_match: assert property (
    timeout_active && timeout_count == burst_write_timeout_value
    |=> write_fifo_flush)
    else $error("time-out match did not flush the write fifo");
  a_flush_only_match: assert property (
    write_fifo_flush |-> $past(timeout_active) &&
      $past(timeout_count) == $past(burst_write_timeout_value))
    else $error("write fifo flushed without a time-out match");
  a_hp_rsvd_zero: assert property (
    s_read_setup(hit_hp) |=> prdata[31:`HP_CTRL_W] == '0)
    else $error("host port control reserved bits not zero");
  a_tmr_rsvd_zero: assert property (
    s_read_setup(hit_tmr) |=> prdata[31:`TIMER_CTRL_W] == '0)
    else $error("timer control reserved bits not zero");
  a_dma_rsvd_zero: assert property (
    s_read_setup(hit_dma) |=> prdata[31:`DMA_CFG_W] == '0)
    else $error("burst config reserved bits not zero");
  a_dma_write_takes: assert property (
    s_write_dma |=> dma_cfg == $past(pwdata[`DMA_CFG_W-1:0]))
    else $error("burst config write not stored");
  a_hp_write_takes: assert property (
    wr_hp |=> hp_ctrl == $past(pwdata[`HP_CTRL_W-1:0]))
    else $error("host port control write not stored");
  a_tmr_write_takes: assert property (
    wr_tmr |=> tmr_ctrl == $past(pwdata[`TIMER_CTRL_W-1:0]))
    else $error("timer control write not stored");
  a_hp_read_data: assert property (
    s_read_setup(hit_hp) |=> prdata[`HP_CTRL_W-1:0] == $past(hp_ctrl))
    else $error("host port control read data wrong");
  a_dma_read_data: assert property (
    s_read_setup(hit_dma) |=> prdata[`DMA_CFG_W-1:0] == $past(dma_ctrl))
    else $error("burst config read data wrong");
  a_tc2_burst_hold: assert property (
    !wr_dma |=> $stable(dma_cfg.xfer_ctrl2_burst_size))
    else $error("controller 2 burst size changed without a write");
  a_tc1_burst_hold: assert property (
    !wr_dma |=> $stable(dma_cfg.xfer_ctrl1_burst_size))
    else $error("controller 1 burst size changed without a write");
  a_tc0_burst_hold: assert property (
    !wr_dma |=> $stable(dma_cfg.xfer_ctrl0_burst_size))
    else $error("controller 0 burst size changed without a write");
  a_reset_defaults: assert property (
    first_cycle |-> dma_cfg == {`TC2_BURST_RESET, `TC1_BURST_RESET,
      `TC0_BURST_RESET} && tmr_ctrl == {`PRESCALE_SEL_RESET,
      `WATCHDOG_RESET_ENABLE_RESET} && hp_ctrl == `HP_CTRL_RESET)
    else $error("fields not at defaults after reset");
  a_fifo_depth_fixed: assert property (
    $changed(dma_cfg) |-> xfer_ctrl1_fifo_depth == `TC1_FIFO_DEPTH &&
      xfer_ctrl0_fifo_depth == `TC0_FIFO_DEPTH &&
      xfer_ctrl2_fifo_depth == `TC2_FIFO_DEPTH)
    else $error("fifo depth followed burst size");
  a_unmapped_error: assert property (
    access_phase && !hit_any |-> pslverr && pready)
    else $error("unmapped access not flagged");

endmodule // peripheral_system_control_regs

// >>> rtl/sysctl_defs.svh
// constants of the peripheral system control register bank
// assumes inclusion by bare name from files under rtl/
`ifndef SYSCTL_DEFS_SVH
`define SYSCTL_DEFS_SVH

// byte addresses of the three registers
`define ADDR_HOST_PORT_CTRL   32'h01c4_0030
`define ADDR_TIMER_AUX_CTRL   32'h01c4_0084
`define ADDR_DMA_BURST_CFG    32'h01c4_0088

// implemented widths, bits above read as zero
`define HP_CTRL_W             10
`define TIMER_CTRL_W          2
`define DMA_CFG_W             6
`define TIMEOUT_W             8

// reset values
`define HP_CTRL_RESET         10'h000
`define WATCHDOG_RESET_ENABLE_RESET           1'h1
`define PRESCALE_SEL_RESET    1'h0
`define TC0_BURST_RESET       2'h0
`define TC1_BURST_RESET       2'h1
`define TC2_BURST_RESET       2'h2

// fixed transfer controller fifo depths in bytes
`define FIFO_DEPTH_W          9
`define TC0_FIFO_DEPTH        9'h080
`define TC1_FIFO_DEPTH        9'h100
`define TC2_FIFO_DEPTH        9'h080

// timer 0 external input prescale ratio
`define PRESCALE_DIVIDE       6

`endif

// >>> rtl/sysctl_pkg.sv
// types of the peripheral system control register bank
// assumes sysctl_defs.svh for widths
`include "sysctl_defs.svh"
package sysctl_pkg;

  typedef enum logic [1:0] {
    BURST_16  = 2'h0,
    BURST_32  = 2'h1,
    BURST_64  = 2'h2,
    BURST_RSV = 2'h3
  } burst_code_t;

  typedef struct packed {
    logic [1:0]            rsvd_zero;
    logic [`TIMEOUT_W-1:0] burst_write_timeout_value;
  } host_port_timeout_ctrl_t;

  typedef struct packed {
    logic timer0_input_prescale_sel;
    logic watchdog_reset_enable;
  } timer_aux_ctrl_t;

  typedef struct packed {
    burst_code_t xfer_ctrl2_burst_size;
    burst_code_t xfer_ctrl1_burst_size;
    burst_code_t xfer_ctrl0_burst_size;
  } dma_burst_size_cfg_t;

endpackage

// >>> rtl/timer0_prescaler.sv
// timer 0 external clock source: pin directly or pin divided by six
// assumes timer0_input_pin is synchronous to pclk
`timescale 1ns/1ps
`include "sysctl_defs.svh"
module timer0_prescaler #(
  parameter int DIVIDE = `PRESCALE_DIVIDE
) (
  input  wire logic pclk,           // clock
  input  wire logic presetn,        // async reset, active low
  input  wire logic prescale_sel,   // 1: divide the pin
  input  wire logic pin,            // timer 0 input pin level
  output logic      clock_out       // timer 0 clock input
);
  localparam int HALF  = DIVIDE / 2;
  localparam int CNT_W = (HALF > 1) ? $clog2(HALF) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);

  if (DIVIDE < 2 || (DIVIDE % 2) != 0) begin : g_bad_divide
    $error("prescale ratio must be even and at least two");
  end

  logic             pin_q;
  logic             div_clk;
  logic [CNT_W-1:0] cnt;
  logic             next_pin_q;
  logic             next_div_clk;
  logic [CNT_W-1:0] next_cnt;
  logic             next_clock_out;
  logic             pin_rise;

  assign pin_rise = pin & ~pin_q;

  // half period of the divided clock spans HALF rising pin edges
  always_comb begin
    next_pin_q     = pin;
    next_cnt       = cnt;
    next_div_clk   = div_clk;
    if (pin_rise) begin
      if (cnt == LAST) begin
        next_cnt     = '0;
        next_div_clk = ~div_clk;
      end else begin
        next_cnt     = cnt + CNT_W'(1);
      end
    end
    next_clock_out = prescale_sel ? div_clk : pin;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q     <= 1'b0;
      cnt       <= '0;
      div_clk   <= 1'b0;
      clock_out <= 1'b0;
    end else begin
      pin_q     <= next_pin_q;
      cnt       <= next_cnt;
      div_clk   <= next_div_clk;
      clock_out <= next_clock_out;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_direct_pin_path: assert property (
    !prescale_sel |=> clock_out == $past(pin))
    else $error("direct timer input does not follow pin");
  a_divide_toggle: assert property (
    pin_rise && cnt == LAST |=> div_clk != $past(div_clk))
    else $error("divided clock missed its toggle");
  a_divide_hold: assert property (
    !(pin_rise && cnt == LAST) |=> $stable(div_clk))
    else $error("divided clock toggled early");
endmodule // timer0_prescaler

// >>> rtl/watchdog_reset_gate.sv
// gates the timer 2 watchdog event onto the device maximum reset request
// assumes watchdog_event is synchronous to pclk
`timescale 1ns/1ps
module watchdog_reset_gate (
  input  wire logic pclk,           // clock
  input  wire logic presetn,        // async reset, active low
  input  wire logic reset_enable,   // 1: event may reset the device
  input  wire logic watchdog_event, // watchdog expiry from timer 2
  output logic      max_reset_req   // maximum reset request, level
);
  logic next_max_reset_req;

  always_comb begin
    next_max_reset_req = watchdog_event & reset_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      max_reset_req <= 1'b0;
    end else begin
      max_reset_req <= next_max_reset_req;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_wdog_reset_pass: assert property (
    watchdog_event && reset_enable |=> max_reset_req)
    else $error("enabled watchdog event gave no reset request");
  a_wdog_reset_block: assert property (
    !(watchdog_event && reset_enable) |=> !max_reset_req)
    else $error("reset request without enabled watchdog event");
endmodule // watchdog_reset_gate
